//--- core/clkstop_pkg.sv
package clkstop_pkg;
   // ---------------------------------------------------------------
   // register map and field layout
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SMSW = 8'h04;
   localparam logic [7:0] OFS_CPU_N = 8'h08;
   localparam logic [7:0] OFS_PCIE_N = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int CTRL_RESTORE_BIT = 0;
   localparam int CTRL_MANAGE_BIT = 3;
   localparam int CTRL_STOPPABLE_LSB = 4;
   localparam int CTRL_FREE_RUN_LSB = 8;
   localparam int SMSW_MANUAL_BIT = 7;
   localparam int SMOOTH_SWITCH_PLL_SELECT_BIT = 6;
   localparam int SMSW_PCIE_OC_BIT = 4;
   localparam int SMSW_CPU_OC_BIT = 3;
   localparam int STAT_CPU_FREQ_LSB = 0;
   localparam int STAT_PCIE_FREQ_LSB = 12;
   localparam int STAT_OWNER_BIT = 24;
   localparam int STAT_STATE_LSB = 28;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] STOPPABLE_RST = 2'h3;
   localparam logic [1:0] FREE_RUN_RST = 2'h0;
   localparam logic [8:0] CPU_NOMINAL = 9'h0C8;
   localparam logic [8:0] PCIE_NOMINAL = 9'h064;
   // ---------------------------------------------------------------
   // timing, clock is 100 MHz
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int RAMP_STEP_NS = 667;
   localparam int LOCK_TIME_NS = 1800000;
   localparam int DIFF_DRIVE_NS = 300000;
   localparam int RAMP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_CYC = LOCK_TIME_NS / CLK_PERIOD_NS;
   localparam int DIFF_DRIVE_CYC = DIFF_DRIVE_NS / CLK_PERIOD_NS;
   localparam int PCI_HALF_CYC = 3;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {PS_WAIT_GOOD, PS_LOCK, PS_RUN, PS_DRAIN, PS_OFF} pwr_state_t;
   typedef struct packed {
      logic [1:0] free_run;
      logic [1:0] stoppable;
      logic manage;
      logic restore;
      logic manual;
      logic pll_sel;
      logic pcie_oc_en;
      logic cpu_oc_en;
   } cfg_t;
   localparam cfg_t CFG_RST = '{free_run: FREE_RUN_RST, stoppable: STOPPABLE_RST,
                                default: 1'b0};
endpackage : clkstop_pkg

//--- core/clock_stop_ctrl.sv
`timescale 1ns/100ps
module clock_stop_ctrl
   import clkstop_pkg::*;
#(
   parameter int LOCK_CYCLES = LOCK_CYC,
   parameter int DIFF_CYCLES = DIFF_DRIVE_CYC
)
(
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic POWER_GOOD_POWER_DOWN_N,
   input wire logic CPU_CLOCK_STOP_N,
   input wire logic PCI_CLOCK_STOP_N,
   output logic [1:0] CPU_CLOCK_TRUE,
   output logic [1:0] CPU_CLOCK_COMPLEMENT,
   output logic [3:0] PCI_CLOCK,
   output logic [1:0] FREE_RUNNING_PCI_CLOCK,
   output logic PCIE_REFERENCE_CLOCK_TRUE,
   output logic PCIE_REFERENCE_CLOCK_COMPLEMENT,
   output logic DIFF_DRIVE_EN,
   output logic VCO_EN,
   output logic XTAL_EN,
   output logic [8:0] CPU_FREQ,
   output logic [8:0] PCIE_FREQ
);
   // one step of the ramp toward the target
   function automatic logic [8:0] ramp_step(input logic [8:0] cur, input logic [8:0] tgt);
      if (cur < tgt)
         ramp_step = cur + 9'h001;
      else if (cur > tgt)
         ramp_step = cur - 9'h001;
      else
         ramp_step = cur;
   endfunction : ramp_step

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   pwr_state_t state_r, state_nxt;
   cfg_t cfg_r;
   logic [8:0] cpu_n_r, pcie_n_r, cpu_freq_r, pcie_freq_r, cpu_freq_nxt, pcie_freq_nxt;
   logic [31:0] prdata_r, rd_mux;
   logic pready_r, pslverr_r;
   logic pin_s1_r, pin_s2_r;
   logic [1:0] pd_cnt_r, cstop_cnt_r;
   logic [17:0] timer_r;
   logic [6:0] ramp_cnt_r;
   logic cpu_phase_r, pci_phase_r;
   logic [1:0] pci_cnt_r;
   logic [5:0] se_gate_r, se_gate_nxt, se_out_r;
   logic [1:0] ct_r, cc_r, ct_nxt;
   logic pt_r, pc_r, diff_drv_r, vco_r, xtal_r;
   logic [1:0] cpu_gate;
   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   wire setup_ok = PSEL & PENABLE & ~pready_r;
   wire acc_done = PSEL & PENABLE & pready_r;
   wire wr_en = acc_done & PWRITE;
   wire hit_ctrl = (PADDR == OFS_CTRL);
   wire hit_smsw = (PADDR == OFS_SMSW);
   wire hit_cpun = (PADDR == OFS_CPU_N);
   wire hit_pcien = (PADDR == OFS_PCIE_N);
   wire hit_stat = (PADDR == OFS_STATUS);
   wire hit_any = hit_ctrl | hit_smsw | hit_cpun | hit_pcien | hit_stat;
   wire comp_rise = cpu_phase_r;               // complement rises at this edge
   wire pci_wrap = (pci_cnt_r == 2'(PCI_HALF_CYC - 1));
   wire pci_fall = pci_wrap & pci_phase_r;
   wire pci_phase_nxt = pci_wrap ? ~pci_phase_r : pci_phase_r;
   wire running = (state_r == PS_RUN);
   wire cold_reset = (state_r == PS_DRAIN) && (state_nxt == PS_OFF)
                     && !cfg_r.restore && !cfg_r.manage;
   wire ramp_tick = (ramp_cnt_r == 7'(RAMP_CYC - 1));
   wire [8:0] cpu_tgt = cfg_r.cpu_oc_en ? cpu_n_r : CPU_NOMINAL;
   wire [8:0] pcie_tgt = cfg_r.pcie_oc_en ? pcie_n_r : PCIE_NOMINAL;
   wire cpu_busy = (cpu_freq_r != cpu_tgt);
   wire pcie_busy = (pcie_freq_r != pcie_tgt);
   // auto picks the moving pll, cpu first if both move at once
   wire owner_pcie = cfg_r.manual ? cfg_r.pll_sel : (~cpu_busy & pcie_busy);
   wire pci_stop_req = ~PCI_CLOCK_STOP_N;

   // read mux, reserved bits read zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl)
      begin
         rd_mux[CTRL_RESTORE_BIT] = cfg_r.restore;
         rd_mux[CTRL_MANAGE_BIT] = cfg_r.manage;
         rd_mux[CTRL_STOPPABLE_LSB +: 2] = cfg_r.stoppable;
         rd_mux[CTRL_FREE_RUN_LSB +: 2] = cfg_r.free_run;
      end
      else if (hit_smsw)
      begin
         rd_mux[SMSW_MANUAL_BIT] = cfg_r.manual;
         rd_mux[SMOOTH_SWITCH_PLL_SELECT_BIT] = cfg_r.pll_sel;
         rd_mux[SMSW_PCIE_OC_BIT] = cfg_r.pcie_oc_en;
         rd_mux[SMSW_CPU_OC_BIT] = cfg_r.cpu_oc_en;
      end
      else if (hit_cpun)
         rd_mux[8:0] = cpu_n_r;
      else if (hit_pcien)
         rd_mux[8:0] = pcie_n_r;
      else if (hit_stat)
      begin
         rd_mux[STAT_CPU_FREQ_LSB +: 9] = cpu_freq_r;
         rd_mux[STAT_PCIE_FREQ_LSB +: 9] = pcie_freq_r;
         rd_mux[STAT_OWNER_BIT] = owner_pcie;
         rd_mux[STAT_STATE_LSB +: 3] = state_r;
      end
   end

   // ---------------------------------------------------------------
   // apb slave: one wait state, pready and data from flops
   // ---------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= setup_ok;
         pslverr_r <= setup_ok & ~hit_any;
         prdata_r <= (setup_ok & ~PWRITE) ? rd_mux : prdata_r;
      end
   end

   // configuration; a cold reset on power-down behaves like power-on
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         cfg_r <= CFG_RST;
         cpu_n_r <= CPU_NOMINAL;
         pcie_n_r <= PCIE_NOMINAL;
      end
      else if (cold_reset)
      begin
         cfg_r <= CFG_RST;
         cpu_n_r <= CPU_NOMINAL;
         pcie_n_r <= PCIE_NOMINAL;
      end
      else if (wr_en && hit_ctrl)
      begin
         cfg_r.restore <= PWDATA[CTRL_RESTORE_BIT];
         cfg_r.manage <= PWDATA[CTRL_MANAGE_BIT];
         cfg_r.stoppable <= PWDATA[CTRL_STOPPABLE_LSB +: 2];
         cfg_r.free_run <= PWDATA[CTRL_FREE_RUN_LSB +: 2];
      end
      else if (wr_en && hit_smsw)
      begin
         cfg_r.manual <= PWDATA[SMSW_MANUAL_BIT];
         cfg_r.pll_sel <= PWDATA[SMOOTH_SWITCH_PLL_SELECT_BIT];
         cfg_r.pcie_oc_en <= PWDATA[SMSW_PCIE_OC_BIT];
         cfg_r.cpu_oc_en <= PWDATA[SMSW_CPU_OC_BIT];
      end
      else if (wr_en && hit_cpun)
         cpu_n_r <= PWDATA[8:0];
      else if (wr_en && hit_pcien)
         pcie_n_r <= PWDATA[8:0];
   end

   // ---------------------------------------------------------------
   // smooth switch: single ramp timer, the non-owner jumps at once
   // ---------------------------------------------------------------
   assign cpu_freq_nxt = owner_pcie ? cpu_tgt
                         : (ramp_tick ? ramp_step(cpu_freq_r, cpu_tgt) : cpu_freq_r);
   assign pcie_freq_nxt = !owner_pcie ? pcie_tgt
                          : (ramp_tick ? ramp_step(pcie_freq_r, pcie_tgt) : pcie_freq_r);

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         ramp_cnt_r <= 7'h00;
         cpu_freq_r <= CPU_NOMINAL;
         pcie_freq_r <= PCIE_NOMINAL;
      end
      else
      begin
         ramp_cnt_r <= ramp_tick ? 7'h00 : ramp_cnt_r + 7'h01;
         cpu_freq_r <= cpu_freq_nxt;
         pcie_freq_r <= pcie_freq_nxt;
      end
   end

   // ---------------------------------------------------------------
   // power sequencing
   // ---------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         PS_WAIT_GOOD:
            if (pin_s2_r)
               state_nxt = PS_LOCK;
         PS_LOCK:
            if (timer_r == 18'(LOCK_CYCLES - 1))
               state_nxt = PS_RUN;
         PS_RUN:
            if (pd_cnt_r == 2'd2)
               state_nxt = PS_DRAIN;
         PS_DRAIN:
            if ((&se_gate_r) && (se_out_r == 6'h00))
               state_nxt = PS_OFF;
         PS_OFF:
            if (POWER_GOOD_POWER_DOWN_N)
               state_nxt = PS_LOCK;
         default:
            state_nxt = PS_WAIT_GOOD;
      endcase
   end

   // the pin is synchronised before entry; the raw level wakes from off
   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         state_r <= PS_WAIT_GOOD;
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pd_cnt_r <= 2'd0;
         timer_r <= 18'h0_0000;
         vco_r <= 1'b1;
         xtal_r <= 1'b1;
         diff_drv_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         pin_s1_r <= POWER_GOOD_POWER_DOWN_N;
         pin_s2_r <= pin_s1_r;
         if (!running)
            pd_cnt_r <= 2'd0;
         else if (comp_rise)
            pd_cnt_r <= pin_s2_r ? 2'd0 : ((pd_cnt_r == 2'd2) ? 2'd2 : pd_cnt_r + 2'd1);
         timer_r <= (state_r == PS_LOCK) ? timer_r + 18'h0_0001 : 18'h0_0000;
         vco_r <= (state_nxt != PS_OFF);
         xtal_r <= (state_nxt != PS_OFF);
         diff_drv_r <= (state_r == PS_RUN) || (state_r == PS_DRAIN)
                       || ((state_r == PS_LOCK) && (timer_r >= 18'(DIFF_CYCLES - 1)));
      end
   end

   // ---------------------------------------------------------------
   // output clocks: cpu toggles each edge, pci divides by 2*PCI_HALF_CYC
   // ---------------------------------------------------------------
   assign cpu_gate = (cstop_cnt_r == 2'd2) ? cfg_r.stoppable : 2'b00;
   // a gated pair holds high once its true phase arrives, so no runt
   assign ct_nxt = running ? ((cpu_gate & ct_r) | {2{~cpu_phase_r}}) : 2'b00;
   // gates move only as the clock falls, so a high phase is never cut short
   assign se_gate_nxt = !pci_fall ? se_gate_r
                        : (!running ? 6'h3F
                           : {~cfg_r.free_run & {2{pci_stop_req}}, {4{pci_stop_req}}});

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         cpu_phase_r <= 1'b0;
         cstop_cnt_r <= 2'd0;
         ct_r <= 2'b00;
         cc_r <= 2'b00;
         pt_r <= 1'b0;
         pc_r <= 1'b0;
      end
      else
      begin
         cpu_phase_r <= ~cpu_phase_r;
         if (comp_rise)
            cstop_cnt_r <= CPU_CLOCK_STOP_N ? 2'd0
                           : ((cstop_cnt_r == 2'd2) ? 2'd2 : cstop_cnt_r + 2'd1);
         ct_r <= ct_nxt;
         cc_r <= running ? ~ct_nxt : 2'b00;
         pt_r <= running & ~cpu_phase_r;
         pc_r <= running & cpu_phase_r;
      end
   end

   always_ff @(posedge CLOCK or negedge NRST)
   begin
      if (!NRST)
      begin
         pci_cnt_r <= 2'd0;
         pci_phase_r <= 1'b0;
         se_gate_r <= 6'h3F;
         se_out_r <= 6'h00;
      end
      else
      begin
         pci_cnt_r <= pci_wrap ? 2'd0 : pci_cnt_r + 2'd1;
         pci_phase_r <= pci_phase_nxt;
         se_gate_r <= se_gate_nxt;
         se_out_r <= {6{pci_phase_nxt}} & ~se_gate_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign CPU_CLOCK_TRUE = ct_r;
   assign CPU_CLOCK_COMPLEMENT = cc_r;
   assign PCI_CLOCK = se_out_r[3:0];
   assign FREE_RUNNING_PCI_CLOCK = se_out_r[5:4];
   assign PCIE_REFERENCE_CLOCK_TRUE = pt_r;
   assign PCIE_REFERENCE_CLOCK_COMPLEMENT = pc_r;
   assign DIFF_DRIVE_EN = diff_drv_r;
   assign VCO_EN = vco_r;
   assign XTAL_EN = xtal_r;
   assign CPU_FREQ = cpu_freq_r;
   assign PCIE_FREQ = pcie_freq_r;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_ramp_rate;
      @(posedge CLOCK) disable iff (!NRST)
      (!$stable(cpu_freq_r) && !$past(owner_pcie)) |-> $past(ramp_tick);
   endproperty
   a_ramp_rate: assert property (p_ramp_rate) else $error("cpu ramp stepped early");
   property p_jump;
      @(posedge CLOCK) disable iff (!NRST)
      owner_pcie |=> (cpu_freq_r == $past(cpu_tgt));
   endproperty
   a_jump: assert property (p_jump) else $error("non-owner did not jump");
   property p_auto_owner;
      @(posedge CLOCK) disable iff (!NRST)
      (!cfg_r.manual && cpu_busy) |-> !owner_pcie;
   endproperty
   a_auto_owner: assert property (p_auto_owner) else $error("auto owner wrong");
   property p_diff_low;
      @(posedge CLOCK) disable iff (!NRST)
      (state_r != PS_RUN) |=> (CPU_CLOCK_TRUE == 2'b00) && !PCIE_REFERENCE_CLOCK_TRUE;
   endproperty
   a_diff_low: assert property (p_diff_low) else $error("diff output not low");
   property p_off_quiet;
      @(posedge CLOCK) disable iff (!NRST)
      !VCO_EN |-> (se_out_r == 6'h00) && (CPU_CLOCK_COMPLEMENT == 2'b00);
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("clock live with vco off");
   property p_cpu_rest;
      @(posedge CLOCK) disable iff (!NRST)
      ($rose(cpu_gate[0]) && running) ##1 running[*4]
         |-> CPU_CLOCK_TRUE[0] && !CPU_CLOCK_COMPLEMENT[0];
   endproperty
   a_cpu_rest: assert property (p_cpu_rest) else $error("cpu pair not parked high");
   property p_cpu_resume;
      @(posedge CLOCK) disable iff (!NRST)
      ($fell(cpu_gate[0]) && running) ##1 running[*4] |-> $changed(CPU_CLOCK_TRUE[0]);
   endproperty
   a_cpu_resume: assert property (p_cpu_resume) else $error("cpu pair did not resume");
   property p_gate_at_fall;
      @(posedge CLOCK) disable iff (!NRST)
      !$stable(se_gate_r) |-> !pci_phase_r && (se_out_r == 6'h00);
   endproperty
   a_gate_at_fall: assert property (p_gate_at_fall) else $error("gate moved mid-high");
   property p_pci_resume;
      @(posedge CLOCK) disable iff (!NRST)
      (running && $rose(PCI_CLOCK_STOP_N)) |-> ##[1:12] PCI_CLOCK[0];
   endproperty
   a_pci_resume: assert property (p_pci_resume) else $error("pci did not resume");
   property p_wake;
      @(posedge CLOCK) disable iff (!NRST)
      (state_r == PS_OFF) && POWER_GOOD_POWER_DOWN_N |=> (state_r == PS_LOCK) ##1 VCO_EN;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake from raw pin");
   property p_manage_keeps;
      @(posedge CLOCK) disable iff (!NRST)
      cfg_r.manage && (state_r == PS_DRAIN) |=> $stable(cfg_r) || $past(wr_en);
   endproperty
   a_manage_keeps: assert property (p_manage_keeps) else $error("config lost");
endmodule : clock_stop_ctrl

//--- sim/chipset_model.sv
`timescale 1ns/100ps
module chipset_model
(
   input wire logic clock,
   input wire logic good,
   input wire logic pd_req,
   input wire logic cpu_req,
   input wire logic pci_req,
   output logic pin_n = 1'b0,
   output logic cpu_stop_n = 1'b1,
   output logic pci_stop_n = 1'b1
);
   // ------------------------------
   // chipset pin drivers
   // ------------------------------
   // pins move just after the rising edge; the device syncs only the power pin, the stop pins are used unsynchronised
   always @(posedge clock)
   begin
      pin_n <= good & ~pd_req;
      cpu_stop_n <= ~cpu_req;
      pci_stop_n <= ~pci_req;
   end
endmodule : chipset_model

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench
   import clkstop_pkg::*;
;
   // ------------------------------
   // signals and instances
   // ------------------------------
   localparam int LOCK = 40;
   localparam int DIFF = 20;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic good = 1'b0;
   logic pd_req = 1'b0;
   logic cpu_req = 1'b0;
   logic pci_req = 1'b0;
   logic pin_n, cpu_stop_n, pci_stop_n, pready, pslverr, pcie_t, pcie_c;
   logic diff_en, vco_en, xtal_en, er, p;
   logic [31:0] prdata, rd;
   logic [1:0] cpu_t, cpu_c, free_pci;
   logic [3:0] pci;
   logic [8:0] cpu_freq, pcie_freq;
   int error_cnt = 0;
   int compares = 0;
   int cycles = 0;
   int w, n;
   chipset_model i_chipset_model (.clock(clock), .good(good), .pd_req(pd_req),
      .cpu_req(cpu_req), .pci_req(pci_req), .pin_n(pin_n), .cpu_stop_n(cpu_stop_n),
      .pci_stop_n(pci_stop_n));
   clock_stop_ctrl #(.LOCK_CYCLES(LOCK), .DIFF_CYCLES(DIFF)) i_clock_stop_ctrl (
      .CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .POWER_GOOD_POWER_DOWN_N(pin_n), .CPU_CLOCK_STOP_N(cpu_stop_n),
      .PCI_CLOCK_STOP_N(pci_stop_n), .CPU_CLOCK_TRUE(cpu_t), .CPU_CLOCK_COMPLEMENT(cpu_c),
      .PCI_CLOCK(pci), .FREE_RUNNING_PCI_CLOCK(free_pci), .PCIE_REFERENCE_CLOCK_TRUE(pcie_t),
      .PCIE_REFERENCE_CLOCK_COMPLEMENT(pcie_c), .DIFF_DRIVE_EN(diff_en), .VCO_EN(vco_en),
      .XTAL_EN(xtal_en), .CPU_FREQ(cpu_freq), .PCIE_FREQ(pcie_freq));
   // clock and hang guard; a whole run needs well under 3000 cycles
   initial
   begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         error_cnt++;
         end_sim;
      end
   end
   // ------------------------------
   // shared tasks
   // ------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_sim
   // apb master: request held until pready is seen high at an edge
   // no wait-state count is assumed; only the cycle guard ends a hang
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // waits for a clock output to move; w holds the cycles taken
   function automatic logic probe(input int s);
      return s == 0 ? cpu_t[0] : (s == 1 ? pci[0] : free_pci[0]);
   endfunction : probe
   task automatic wait_toggle(input int s, input int lim);
      w = 0;
      @(posedge clock);
      p = probe(s);
      do
      begin
         @(posedge clock);
         w++;
      end
      while (probe(s) === p && w < lim);
      check(32'(w < lim), 1);
   endtask : wait_toggle
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_regs;
      apb(0, OFS_CTRL, 0);
      check(rd, 32'h0000_0030);
      check(32'(er), 32'h0000_0000);
      apb(0, OFS_SMSW, 0);
      check(rd, 32'h0000_0000);
      apb(0, 8'h20, 0);
      check(rd, 32'h0000_0000);
      check(32'(er), 32'h0000_0001);
   endtask : t_regs
   task automatic t_power_up;
      good <= 1'b1;
      wait_toggle(0, LOCK + 30);
      check(32'(diff_en), 1);
      wait_toggle(1, 8);
   endtask : t_power_up
   // one pll retargeted per write so the ramp owner is unambiguous
   task automatic t_smooth;
      apb(1, OFS_CPU_N, 32'h0000_00CA);
      apb(1, OFS_SMSW, 32'h0000_0008);
      apb(0, OFS_STATUS, 0);
      check(32'(rd[24]), 0);
      n = 0;
      while (cpu_freq === 9'h0C8 && n < 300)
      begin
         @(posedge clock);
         n++;
      end
      check(32'(cpu_freq), 32'h0000_00C9);
      n = 0;
      while (cpu_freq === 9'h0C9 && n < 300)
      begin
         @(posedge clock);
         n++;
      end
      check(32'(n >= RAMP_CYC - 1 && cpu_freq === 9'h0CA), 1);
      // cpu is settled, so auto mode must hand the ramp to the pcie pll
      apb(1, OFS_PCIE_N, 32'h0000_0065);
      apb(1, OFS_SMSW, 32'h0000_0018);
      apb(0, OFS_STATUS, 0);
      check({rd[24], rd[20:12]}, {1'b1, 9'h064});
      n = 0;
      while (pcie_freq === 9'h064 && n < 300)
      begin
         @(posedge clock);
         n++;
      end
      check(32'(pcie_freq), 32'h0000_0065);
      apb(1, OFS_SMSW, 32'h0000_00C8);
      apb(0, OFS_STATUS, 0);
      check(32'(rd[24]), 1);
      apb(1, OFS_CPU_N, 32'h0000_00D0);
      repeat (20) @(posedge clock);
      check(32'(cpu_freq), 32'h0000_00D0);
   endtask : t_smooth
   task automatic t_cpu_stop;
      apb(1, OFS_CTRL, 32'h0000_0010);
      cpu_req <= 1'b1;
      repeat (18) @(posedge clock);
      check({cpu_t[0], cpu_c[0]}, 2'b10);
      p = cpu_t[1];
      @(posedge clock);
      check({cpu_t[0], cpu_c[0], cpu_t[1]}, {2'b10, ~p});
      cpu_req <= 1'b0;
      wait_toggle(0, 8);
   endtask : t_cpu_stop
   task automatic t_pci_stop;
      apb(1, OFS_CTRL, 32'h0000_0130);
      pci_req <= 1'b1;
      repeat (16) @(posedge clock);
      check({pci, free_pci[1]}, 0);
      wait_toggle(2, 8);
      pci_req <= 1'b0;
      wait_toggle(1, 16);
   endtask : t_pci_stop
   // outputs must already be low when the oscillators drop
   task automatic t_pd(input logic [31:0] cfg, input logic [31:0] exp);
      apb(1, OFS_CTRL, cfg);
      pd_req <= 1'b1;
      n = 0;
      while (vco_en !== 1'b0 && n < 40)
      begin
         @(posedge clock);
         n++;
      end
      check({cpu_t, cpu_c, pci, free_pci, pcie_t, pcie_c}, 0);
      check({vco_en, xtal_en}, 0);
      // differential drivers let go one cycle after the oscillators
      @(posedge clock);
      check({vco_en, xtal_en, diff_en}, 0);
      apb(0, OFS_CTRL, 0);
      check(rd, exp);
      pd_req <= 1'b0;
      wait_toggle(0, LOCK + 30);
      check(32'(diff_en), 1);
   endtask : t_pd
   // ------------------------------
   // main sequence
   // ------------------------------
   initial
   begin
      repeat (19) @(posedge clock);
      check({cpu_t, cpu_c, pci, free_pci, pcie_t, pcie_c, vco_en, xtal_en, diff_en}, 3'b110);
      check({cpu_freq, pcie_freq}, {CPU_NOMINAL, PCIE_NOMINAL});
      @(posedge clock);
      nrst <= 1'b1;
      t_regs;
      t_power_up;
      t_smooth;
      t_cpu_stop;
      t_pci_stop;
      t_pd(32'h0000_0130, 32'h0000_0030);
      t_pd(32'h0000_0131, 32'h0000_0131);
      t_pd(32'h0000_0138, 32'h0000_0138);
      end_sim;
   end
endmodule : testbench
